// >>> rtl/dicr_top.sv
// Digital input conditioning, object access and summary word
`timescale 1ns/1ps
`default_nettype none
module dicr_top
	import dicr_pkg::*;
#(
	parameter int N_IN = DICR_N_IN,
	parameter int N_ROUTE = DICR_N_ROUTE,
	parameter logic [15:0] CLKDIR_MASK = 16'h0000
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [N_IN-1:0] phys_in,
	input wire logic [2:0] hall_in,
	input wire logic [2:0] enc_in,
	input wire logic usb_pwr,
	input wire logic eth_active,
	input wire logic [7:0] dip_sw,
	input wire logic od_wr,
	input wire logic od_rd,
	input wire logic [15:0] od_index,
	input wire logic [7:0] od_subidx,
	input wire logic [31:0] od_wdata,
	output logic od_ack,
	output logic od_err,
	output logic [31:0] od_rdata,
	output logic [N_ROUTE-1:0] input_summary_word,
	output logic neg_limit,
	output logic pos_limit,
	output logic home_sw,
	output logic [N_IN-1:0] thr_sel_24v,
	output logic [N_IN-1:0] diff_sel
);
	// Control words
	logic [31:0] sfe_r; // Special function enable
	logic [31:0] pol_r; // Polarity invert
	logic [31:0] fen_r; // Force enable
	logic [31:0] fval_r; // Force value
	logic [31:0] thr_r; // Threshold select
	logic [31:0] diff_r; // Differential select
	logic [31:0] rten_r; // Routing enable
	logic [7:0] route_r [N_ROUTE]; // Routing table
	// Sampled pin state
	logic [N_IN-1:0] raw_r; // Raw input levels
	logic [15:0] aux_r; // Auxiliary sources
	// Conditioning results
	logic [N_IN-1:0] polar; // After inversion
	logic [N_IN-1:0] cond; // After forcing
	logic [31:0] dflt_sum; // Summary without routing
	logic [N_ROUTE-1:0] sum_nxt; // Next summary word
	logic route_on; // Routing in use
	// Access decode
	logic hit_ctrl; // Input control array addressed
	logic hit_route; // Routing array addressed
	logic route_ok; // Routing subindex in range
	logic [5:0] route_idx; // Routing table slot
	logic [31:0] rd_nxt; // Read data next
	logic err_nxt; // Access error next

	dicr_if #(.N_IN(N_IN), .N_AUX(DICR_N_AUX), .N_ROUTE(N_ROUTE)) rif ();

	dicr_router #(.N_ROUTE(N_ROUTE)) u_router (
		.rif(rif.rtr)
	);

	// Sample pins each cycle
	// raw levels kept untouched
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			raw_r <= '0;
			aux_r <= '0;
		end else begin
			raw_r <= phys_in;
			aux_r <= {dip_sw, eth_active, usb_pwr, enc_in, hall_in};
		end
	end

	// Polarity then forcing per input
	always_comb begin
		polar = raw_r ^ (pol_r[N_IN-1:0] & ~CLKDIR_MASK[N_IN-1:0]);
		// forced bits take the force value
		cond = (polar & ~fen_r[N_IN-1:0]) | (fval_r[N_IN-1:0] & fen_r[N_IN-1:0]);
	end

	// Feed the routing matrix
	assign rif.cond = cond;
	assign rif.aux = aux_r;
	genvar g;
	generate
		for (g = 0; g < N_ROUTE; g++) begin : g_rt
			assign rif.route_sel[g] = route_r[g];
		end
	endgenerate

	// Default summary layout
	always_comb begin
		dflt_sum = '0;
		// special functions gated by their enables
		dflt_sum[DICR_BIT_NEG] = cond[DICR_BIT_NEG] & sfe_r[DICR_BIT_NEG];
		dflt_sum[DICR_BIT_POS] = cond[DICR_BIT_POS] & sfe_r[DICR_BIT_POS];
		dflt_sum[DICR_BIT_HOME] = cond[DICR_BIT_HOME] & sfe_r[DICR_BIT_HOME];
		dflt_sum[31:16] = cond;
	end

	// Pick routed or default summary
	assign route_on = rten_r[DICR_BIT_RTEN];
	always_comb begin
		sum_nxt = '0;
		if (route_on) begin
			sum_nxt = rif.routed;
		end else begin
			sum_nxt[31:0] = dflt_sum;
		end
	end

	// Registered summary and special outputs
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			input_summary_word <= '0;
			neg_limit <= 1'b0;
			pos_limit <= 1'b0;
			home_sw <= 1'b0;
		end else begin
			input_summary_word <= sum_nxt;
			// limit and home from enabled bits
			neg_limit <= dflt_sum[DICR_BIT_NEG];
			pos_limit <= dflt_sum[DICR_BIT_POS];
			home_sw <= dflt_sum[DICR_BIT_HOME];
		end
	end

	// Address decode
	assign hit_ctrl = (od_index == DICR_IDX_CTRL);
	assign hit_route = (od_index == DICR_IDX_ROUTE);
	assign route_ok = (od_subidx != DICR_SUB_COUNT) && (od_subidx <= DICR_ROUTE_COUNT);
	assign route_idx = 6'(od_subidx - 8'h01);

	// Control word writes
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sfe_r <= DICR_WORD_RST;
			pol_r <= DICR_WORD_RST;
			fen_r <= DICR_WORD_RST;
			fval_r <= DICR_WORD_RST;
			thr_r <= DICR_WORD_RST;
			diff_r <= DICR_WORD_RST;
			rten_r <= DICR_WORD_RST;
		end else if (od_wr && hit_ctrl) begin
			unique case (od_subidx)
				DICR_SUB_SFE: sfe_r <= od_wdata;
				DICR_SUB_POL: pol_r <= od_wdata;
				DICR_SUB_FEN: fen_r <= od_wdata;
				DICR_SUB_FVAL: fval_r <= od_wdata;
				DICR_SUB_THR: thr_r <= od_wdata;
				DICR_SUB_DIFF: diff_r <= od_wdata;
				DICR_SUB_RTEN: rten_r <= od_wdata;
				// Raw word and count ignore writes
				default: ;
			endcase
		end
	end

	// Routing table writes
	// one 8-bit code per summary bit
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < N_ROUTE; i++) begin
				route_r[i] <= DICR_ROUTE_RST;
			end
		end else if (od_wr && hit_route && route_ok) begin
			route_r[route_idx] <= od_wdata[7:0];
		end
	end

	// Threshold and differential pins
	// bit n-1 picks 24 V for input n
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			thr_sel_24v <= '0;
			diff_sel <= '0;
		end else begin
			thr_sel_24v <= thr_r[N_IN-1:0];
			diff_sel <= diff_r[N_IN-1:0];
		end
	end

	// Read mux and error decode
	always_comb begin
		rd_nxt = '0;
		err_nxt = 1'b0;
		if (hit_ctrl) begin
			unique case (od_subidx)
				DICR_SUB_COUNT: rd_nxt = {24'h000000, DICR_CTRL_COUNT};
				DICR_SUB_SFE: rd_nxt = sfe_r;
				DICR_SUB_POL: rd_nxt = pol_r;
				DICR_SUB_FEN: rd_nxt = fen_r;
				DICR_SUB_FVAL: rd_nxt = fval_r;
				DICR_SUB_RAW: rd_nxt = {16'h0000, raw_r};
				DICR_SUB_THR: rd_nxt = thr_r;
				DICR_SUB_DIFF: rd_nxt = diff_r;
				DICR_SUB_RTEN: rd_nxt = rten_r;
				default: err_nxt = 1'b1;
			endcase
		end else if (hit_route) begin
			// Count entry or table slot
			if (od_subidx == DICR_SUB_COUNT) begin
				rd_nxt = {24'h000000, DICR_ROUTE_COUNT};
			end else if (route_ok) begin
				rd_nxt = {24'h000000, route_r[route_idx]};
			end else begin
				err_nxt = 1'b1;
			end
		end else if (od_index == DICR_IDX_SUMMARY && od_subidx == DICR_SUB_COUNT) begin
			rd_nxt = input_summary_word[31:0];
			err_nxt = od_wr;
		end else begin
			// Unknown object, or summary object at a subindex other than 0
			err_nxt = 1'b1;
		end
	end

	// Access answer one cycle after request
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			od_ack <= 1'b0;
			od_err <= 1'b0;
			od_rdata <= '0;
		end else begin
			od_ack <= od_wr | od_rd;
			od_err <= (od_wr | od_rd) & err_nxt;
			od_rdata <= od_rd ? rd_nxt : '0;
		end
	end

	// Raw word tracks pins
	raw_track_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$past(nrst) |-> raw_r == $past(phys_in))
		else $error("raw word does not follow pins");
	// Disabled special function stays low
	sfe_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!sfe_r[DICR_BIT_NEG] |=> !neg_limit)
		else $error("negative limit seen while disabled");
	// Home bit from input three
	home_bit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(sfe_r[DICR_BIT_HOME] && cond[DICR_BIT_HOME]) |=> home_sw)
		else $error("home switch not reported");
	// Level half independent of enables
	level_half_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!route_on |=> input_summary_word[31:16] == $past(cond))
		else $error("level half of summary wrong");
	// Inversion of ordinary inputs
	polarity_map_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(fen_r[N_IN-1:0] == '0) |-> cond == (raw_r ^ (pol_r[N_IN-1:0] & ~CLKDIR_MASK)))
		else $error("polarity inversion wrong");
	// Forced inputs take their force values
	force_value_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(cond & fen_r[N_IN-1:0]) == (fval_r[N_IN-1:0] & fen_r[N_IN-1:0]))
		else $error("forced value not used");
	// Threshold write reaches pins
	thr_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(od_wr && hit_ctrl && od_subidx == DICR_SUB_THR) |=> ##1 thr_sel_24v == $past(od_wdata[N_IN-1:0], 2))
		else $error("threshold select not applied");
	// Code one gives constant one
	const_one_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(route_on && route_r[20] == DICR_CODE_ONE) |=> input_summary_word[20])
		else $error("constant one missing");
	// Code zero gives constant zero
	const_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(route_on && route_r[1] == DICR_CODE_ZERO) |=> !input_summary_word[1])
		else $error("constant zero missing");
	// Undefined code reads zero
	undef_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(route_on && route_r[2] == 8'h26) |=> !input_summary_word[2])
		else $error("undefined code not zero");
	// Routing count answer
	route_count_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		(od_rd && hit_route && od_subidx == DICR_SUB_COUNT) |=> od_ack && od_rdata == 32'h0000_0024)
		else $error("routing count wrong");

	// Main scenarios
	route_use_c: cover property (@(posedge sys_clk) disable iff (!nrst) route_on && input_summary_word[0]);
	forced_c: cover property (@(posedge sys_clk) disable iff (!nrst)
		fen_r[DICR_BIT_HOME] && cond[DICR_BIT_HOME] != polar[DICR_BIT_HOME]);
	limit_c: cover property (@(posedge sys_clk) disable iff (!nrst) neg_limit && pos_limit && home_sw);
endmodule : dicr_top
`default_nettype wire

// >>> pkg/dicr_pkg.sv
// Constants for the digital input conditioning and routing block
package dicr_pkg;
	// Object dictionary indices of this block
	localparam logic [15:0] DICR_IDX_CTRL = 16'h3240;
	localparam logic [15:0] DICR_IDX_ROUTE = 16'h3242;
	localparam logic [15:0] DICR_IDX_SUMMARY = 16'h60FD;
	// Subindices of the input control array
	localparam logic [7:0] DICR_SUB_COUNT = 8'h00;
	localparam logic [7:0] DICR_SUB_SFE = 8'h01;
	localparam logic [7:0] DICR_SUB_POL = 8'h02;
	localparam logic [7:0] DICR_SUB_FEN = 8'h03;
	localparam logic [7:0] DICR_SUB_FVAL = 8'h04;
	localparam logic [7:0] DICR_SUB_RAW = 8'h05;
	localparam logic [7:0] DICR_SUB_THR = 8'h06;
	localparam logic [7:0] DICR_SUB_DIFF = 8'h07;
	localparam logic [7:0] DICR_SUB_RTEN = 8'h08;
	// Highest subindex values read back
	localparam logic [7:0] DICR_CTRL_COUNT = 8'h08;
	localparam logic [7:0] DICR_ROUTE_COUNT = 8'h24;
	// Reset values
	localparam logic [31:0] DICR_WORD_RST = 32'h0000_0000;
	localparam logic [7:0] DICR_ROUTE_RST = 8'h00;
	// Special function bit positions
	localparam int DICR_BIT_NEG = 0;
	localparam int DICR_BIT_POS = 1;
	localparam int DICR_BIT_HOME = 2;
	// Routing enable bit in the routing enable word
	localparam int DICR_BIT_RTEN = 0;
	// Routing code fields and ranges
	localparam logic [7:0] DICR_CODE_ZERO = 8'h00;
	localparam logic [7:0] DICR_CODE_ONE = 8'h80;
	localparam logic [6:0] DICR_BASE_PHYS_LO = 7'h01;
	localparam logic [6:0] DICR_BASE_PHYS_HI = 7'h10;
	localparam logic [6:0] DICR_BASE_AUX_LO = 7'h41;
	localparam logic [6:0] DICR_BASE_AUX_HI = 7'h50;
	// Counts
	localparam int DICR_N_IN = 16;
	localparam int DICR_N_AUX = 16;
	localparam int DICR_N_ROUTE = 36;
endpackage : dicr_pkg

// >>> pkg/dicr_if.sv
// Carrier between the control logic and the routing matrix
`timescale 1ns/1ps
`default_nettype none
interface dicr_if
	import dicr_pkg::*;
#(
	parameter int N_IN = DICR_N_IN,
	parameter int N_AUX = DICR_N_AUX,
	parameter int N_ROUTE = DICR_N_ROUTE
);
	logic [N_IN-1:0] cond; // Conditioned physical inputs
	logic [N_AUX-1:0] aux; // Hall, encoder, USB, link, DIP sources
	logic [7:0] route_sel [N_ROUTE]; // Routing codes
	logic [N_ROUTE-1:0] routed; // Routed summary bits
	modport ctrl (output cond, output aux, output route_sel, input routed);
	modport rtr (input cond, input aux, input route_sel, output routed);
endinterface : dicr_if
`default_nettype wire

// >>> rtl/dicr_router.sv
// Routing matrix choosing the source of each summary bit
`timescale 1ns/1ps
`default_nettype none
module dicr_router
	import dicr_pkg::*;
#(
	parameter int N_ROUTE = DICR_N_ROUTE
) (
	dicr_if.rtr rif
);
	// One selector per summary bit
	genvar k;
	generate
		for (k = 0; k < N_ROUTE; k++) begin : g_sel
			logic [6:0] base; // Code without inversion bit
			logic inv; // Inversion bit of the code
			assign base = rif.route_sel[k][6:0];
			assign inv = rif.route_sel[k][7];
			always_comb begin
				if (base == 7'h00) begin
					rif.routed[k] = inv;
				end else if (base >= DICR_BASE_PHYS_LO && base <= DICR_BASE_PHYS_HI) begin
					rif.routed[k] = rif.cond[4'(base - DICR_BASE_PHYS_LO)] ^ inv;
				end else if (base >= DICR_BASE_AUX_LO && base <= DICR_BASE_AUX_HI) begin
					rif.routed[k] = rif.aux[4'(base - DICR_BASE_AUX_LO)] ^ inv;
				end else begin
					rif.routed[k] = 1'b0;
				end
			end
		end
	endgenerate
endmodule : dicr_router
`default_nettype wire

// >>> dv/dicr_sensors.sv
// Model of the field switches, Hall, encoder, USB, link and DIP sources
`timescale 1ns/1ps
`default_nettype none
module dicr_sensors (
	input wire logic [15:0] want_pins,
	input wire logic [15:0] want_aux,
	output logic [15:0] phys_in,
	output logic [2:0] hall_in,
	output logic [2:0] enc_in,
	output logic usb_pwr,
	output logic eth_active,
	output logic [7:0] dip_sw
);
	// Switch contacts follow the commanded levels directly
	assign phys_in = want_pins;
	// Aux order: Hall U,V,W, encoder A,B,Index, USB, link, DIP 1..8
	assign {dip_sw, eth_active, usb_pwr, enc_in, hall_in} = want_aux;
endmodule : dicr_sensors
`default_nettype wire

// >>> dv/dicr_top_bench.sv
// Self-checking bench for the input conditioning and routing block
`timescale 1ns/1ps
`default_nettype none
module dicr_top_bench import dicr_pkg::*;;
	localparam logic [15:0] MASK = 16'h8000; // Input 16 acts as clock input
	logic sys_clk, nrst, od_wr, od_rd, od_ack, od_err;
	logic [15:0] od_index, pins, aux, phys_in, thr_sel_24v, diff_sel;
	logic [7:0] od_subidx, dip_sw;
	logic [31:0] od_wdata, od_rdata;
	logic [35:0] input_summary_word;
	logic [2:0] hall_in, enc_in;
	logic usb_pwr, eth_active, neg_limit, pos_limit, home_sw;
	logic [31:0] w [1:8]; // Model of the control words
	logic [7:0] rt [36]; // Model of the routing codes
	logic [15:0] pat [4] = '{16'h0000, 16'hFFFF, 16'h8005, 16'h7FFA};
	int errors, n_checks, cyc;

	dicr_top #(.CLKDIR_MASK(MASK)) dicr_top_inst (.sys_clk(sys_clk), .nrst(nrst), .phys_in(phys_in),
		.hall_in(hall_in), .enc_in(enc_in), .usb_pwr(usb_pwr), .eth_active(eth_active), .dip_sw(dip_sw),
		.od_wr(od_wr), .od_rd(od_rd), .od_index(od_index), .od_subidx(od_subidx), .od_wdata(od_wdata),
		.od_ack(od_ack), .od_err(od_err), .od_rdata(od_rdata), .input_summary_word(input_summary_word),
		.neg_limit(neg_limit), .pos_limit(pos_limit), .home_sw(home_sw), .thr_sel_24v(thr_sel_24v),
		.diff_sel(diff_sel));
	dicr_sensors dicr_sensors_inst (.want_pins(pins), .want_aux(aux), .phys_in(phys_in), .hall_in(hall_in),
		.enc_in(enc_in), .usb_pwr(usb_pwr), .eth_active(eth_active), .dip_sw(dip_sw));

	// Clock generator
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 10000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One object access, left asserted so accesses can run back to back
	task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
		input logic e);
		od_wr = wr;
		od_rd = ~wr;
		od_index = idx;
		od_subidx = sub;
		od_wdata = d;
		@(negedge sys_clk);
		chk(36'({od_ack, od_err}), {34'h0, 1'b1, e});
		if (!wr && !e) chk(36'(od_rdata), 36'(d));
	endtask : acc

	task automatic idle();
		od_wr = 1'b0;
		od_rd = 1'b0;
		@(negedge sys_clk);
	endtask : idle

	task automatic set(input logic [7:0] sub, input logic [31:0] v);
		acc(1'b1, DICR_IDX_CTRL, sub, v, 1'b0);
		w[sub] = v;
	endtask : set

	// Conditioned inputs: inversion first, then forcing
	function automatic logic [15:0] cond();
		return (pins ^ (w[2][15:0] & ~MASK)) & ~w[3][15:0] | w[4][15:0] & w[3][15:0];
	endfunction : cond

	function automatic logic src(input logic [7:0] cd, input logic [15:0] c);
		logic [6:0] b;
		b = cd[6:0];
		if (b == 7'h00) return cd[7];
		if (b >= 7'h01 && b <= 7'h10) return c[b-7'h01] ^ cd[7];
		if (b >= 7'h41 && b <= 7'h50) return aux[b-7'h41] ^ cd[7];
		return 1'b0;
	endfunction : src

	task automatic chk_all();
		logic [35:0] s;
		logic [15:0] c;
		idle();
		repeat (2) @(negedge sys_clk);
		c = cond();
		s = {4'h0, c, 13'h0, c[2:0] & w[1][2:0]};
		if (w[8][0]) begin
			for (int k = 0; k < 36; k++) s[k] = src(rt[k], c);
		end
		chk(input_summary_word, s);
		chk(36'({home_sw, pos_limit, neg_limit}), 36'(c[2:0] & w[1][2:0]));
		chk(36'({thr_sel_24v, diff_sel}), 36'({w[6][15:0], w[7][15:0]}));
		acc(1'b0, DICR_IDX_SUMMARY, 8'h00, s[31:0], 1'b0);
		acc(1'b0, DICR_IDX_CTRL, DICR_SUB_RAW, 32'(pins), 1'b0);
		idle();
	endtask : chk_all

	initial begin
		{nrst, od_wr, od_rd, od_index, od_subidx, od_wdata, pins, aux} = '0;
		{errors, n_checks, cyc} = '0;
		foreach (w[i]) w[i] = '0;
		foreach (rt[i]) rt[i] = '0;
		repeat (5) @(negedge sys_clk);
		nrst = 1'b1;
		// Reset values
		acc(1'b0, DICR_IDX_CTRL, DICR_SUB_COUNT, 32'h08, 1'b0);
		acc(1'b0, DICR_IDX_ROUTE, DICR_SUB_COUNT, 32'h24, 1'b0);
		for (int i = 1; i <= 8; i++) acc(1'b0, DICR_IDX_CTRL, 8'(i), 32'h0, 1'b0);
		acc(1'b0, DICR_IDX_ROUTE, 8'h24, 32'h0, 1'b0);
		$display("test reset done");
		// Read back every writable word, raw word stays read-only
		for (int i = 1; i <= 8; i++) begin
			if (i != 5) set(8'(i), 32'hA5A5_0000 | 32'(i << 4));
			acc(1'b0, DICR_IDX_CTRL, 8'(i), w[i], 1'b0);
		end
		acc(1'b1, DICR_IDX_CTRL, DICR_SUB_RAW, 32'hFFFF_FFFF, 1'b0);
		acc(1'b1, DICR_IDX_CTRL, DICR_SUB_COUNT, 32'h55, 1'b0);
		acc(1'b0, DICR_IDX_CTRL, DICR_SUB_COUNT, 32'h08, 1'b0);
		acc(1'b1, DICR_IDX_SUMMARY, 8'h00, 32'h1, 1'b1);
		acc(1'b0, 16'h3241, 8'h01, 32'h0, 1'b1);
		acc(1'b0, DICR_IDX_ROUTE, 8'h25, 32'h0, 1'b1);
		acc(1'b0, DICR_IDX_CTRL, 8'h09, 32'h0, 1'b1);
		chk_all();
		$display("test access done");
		// Special functions, inversion, forcing, thresholds
		set(DICR_SUB_SFE, 32'hFFFF_0007);
		set(DICR_SUB_POL, 32'h0000_8003);
		set(DICR_SUB_FEN, 32'h0000_0104);
		set(DICR_SUB_FVAL, 32'h0000_0004);
		set(DICR_SUB_THR, 32'hFFFF_1234);
		set(DICR_SUB_RTEN, 32'h0);
		foreach (pat[i]) begin
			pins = pat[i];
			chk_all();
		end
		// Configurer clears all special functions
		set(DICR_SUB_SFE, 32'h0);
		chk_all();
		$display("test conditioning done");
		// Every routing code through at least one entry, two source patterns
		set(DICR_SUB_RTEN, 32'h1);
		pins = 16'h5A3C;
		aux = 16'hA5C3;
		for (int p = 0; p < 2; p++) begin
			for (int b = 0; b < 256; b += 36) begin
				for (int k = 0; k < 36; k++) begin
					rt[k] = 8'(b + k);
					acc(1'b1, DICR_IDX_ROUTE, 8'(k + 1), 32'(rt[k]), 1'b0);
				end
				acc(1'b0, DICR_IDX_ROUTE, 8'h24, 32'(rt[35]), 1'b0);
				chk_all();
			end
			aux = ~aux;
			pins = ~pins;
		end
		$display("test routing done");
		// Reset in mid-run clears configuration
		nrst = 1'b0;
		foreach (w[i]) w[i] = '0;
		foreach (rt[i]) rt[i] = '0;
		repeat (2) @(negedge sys_clk);
		nrst = 1'b1;
		acc(1'b0, DICR_IDX_ROUTE, 8'h01, 32'h0, 1'b0);
		chk_all();
		$display("test second reset done");
		report_and_stop();
	end
endmodule : dicr_top_bench
`default_nettype wire
